// ==== rtl/irq_pkg.sv ====
// constants for the interrupt request and time-base block
package irq_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] OFS_TICK_CTRL = 4'h0;
	localparam logic [3:0] OFS_ENABLES = 4'h1;
	localparam logic [3:0] OFS_FLAGS = 4'h2;
	localparam logic [3:0] OFS_GROUP = 4'h3;
	localparam logic [3:0] OFS_TIMER_EN = 4'h4;
	localparam logic [3:0] OFS_TIMER_FLAGS = 4'h5;
	localparam logic [3:0] OFS_STATUS = 4'h6;
	// time-base control fields and reset value
	localparam int TB_ON_BIT = 7;
	localparam int TB_CK_BIT = 6;
	localparam int TB1_LSB = 4;
	localparam int TB_LP_BIT = 3;
	localparam int TB0_LSB = 0;
	localparam logic [7:0] TICK_CTRL_RST = 8'h37;
	localparam int TB1_BASE_EXP = 12;
	localparam int TB0_BASE_EXP = 8;
	localparam int TB_DIV_BITS = 16;
	localparam int SYS_DIV = 4;
	// enable and flag bit positions, which also give vector order
	localparam int SRC_ADC = 0;
	localparam int SRC_TB0 = 1;
	localparam int SRC_TB1 = 2;
	localparam int SRC_SIM = 3;
	localparam int SRC_UART = 4;
	localparam int SRC_MF0 = 5;
	localparam int SRC_MF1 = 6;
	localparam int SRC_MF2 = 7;
	localparam int NUM_SRC = 8;
	// group register: eeprom and low-supply flags/enables
	localparam int GRP_EE_F = 0;
	localparam int GRP_LV_F = 1;
	localparam int GRP_EE_E = 2;
	localparam int GRP_LV_E = 3;
	// vector addresses, lowest first
	localparam logic [11:0] VEC_BASE = 12'h0004;
	localparam logic [11:0] VEC_STEP = 12'h0004;
endpackage

// ==== rtl/irq_timebase.sv ====
// interrupt request flags, vectoring, time-base dividers and wake-up
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module irq_timebase #(
	parameter int NUM_TM = 2
)(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic dedicated_tick_clock_i,
	input wire logic conv_done_i,
	input wire logic serial_event_i,
	input wire logic [5:0] uart_event_i,
	input wire logic eeprom_write_end_i,
	input wire logic low_supply_detector_i,
	input wire logic [NUM_TM-1:0] timer_match_a_i,
	input wire logic [NUM_TM-1:0] timer_match_p_i,
	input wire logic stack_full_i,
	input wire logic take_ready_i,
	input wire logic reti_i,
	output logic take_o,
	output logic push_pc_o,
	output logic [11:0] vector_o,
	output logic wake_o,
	output logic slow_crystal_low_power_o
);
	initial
		if (NUM_TM < 1 || NUM_TM > 4)
			$error("NUM_TM must be 1 to 4");

	logic [7:0] tick_ctrl_r;
	logic [7:0] enable_r;
	logic [7:0] flag_r;
	logic [3:0] group_r;
	logic [2*NUM_TM-1:0] tm_en_r;
	logic [2*NUM_TM-1:0] tm_flag_r;
	logic global_irq_enable_r;
	logic [7:0] flag_prev_r;
	logic [1:0] tick_sync_r;
	logic tick_clk_prev_r;
	logic [1:0] sys_div_r;
	logic [irq_pkg::TB_DIV_BITS-1:0] div_r;
	logic [irq_pkg::TB_DIV_BITS-1:0] div_nxt;
	logic tick_en;
	logic tick0_ovf;
	logic tick1_ovf;
	logic [7:0] pending;
	logic [7:0] grant;
	logic [2:0] grant_idx;
	logic take_now;
	logic [2*NUM_TM-1:0] tm_set;
	logic [2:0] grp_hit;
	logic [7:0] src_set;
	logic wr_tick, wr_en, wr_flag, wr_grp, wr_tmen, wr_tmf;

	assign wr_tick = reg_wr_i && reg_addr_i == irq_pkg::OFS_TICK_CTRL;
	assign wr_en = reg_wr_i && reg_addr_i == irq_pkg::OFS_ENABLES;
	assign wr_flag = reg_wr_i && reg_addr_i == irq_pkg::OFS_FLAGS;
	assign wr_grp = reg_wr_i && reg_addr_i == irq_pkg::OFS_GROUP;
	assign wr_tmen = reg_wr_i && reg_addr_i == irq_pkg::OFS_TIMER_EN;
	assign wr_tmf = reg_wr_i && reg_addr_i == irq_pkg::OFS_TIMER_FLAGS;

	// time-base control register
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			tick_ctrl_r <= irq_pkg::TICK_CTRL_RST;
		else if (wr_tick)
			tick_ctrl_r <= reg_wdata_i;
	end

	// dedicated tick clock is synchronised then edge-detected
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			tick_sync_r <= 2'b00;
			tick_clk_prev_r <= 1'b0;
			sys_div_r <= 2'b00;
		end
		else
		begin
			tick_sync_r <= {tick_sync_r[0], dedicated_tick_clock_i};
			tick_clk_prev_r <= tick_sync_r[1];
			sys_div_r <= sys_div_r + 2'd1;
		end
	end

	// one tick per tick-clock period from the selected source
	always_comb
	begin
		if (tick_ctrl_r[irq_pkg::TB_CK_BIT])
			tick_en = sys_div_r == 2'(irq_pkg::SYS_DIV - 1);
		else
			tick_en = tick_sync_r[1] && !tick_clk_prev_r;
	end

	// shared divider, held clear while off
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !tick_ctrl_r[irq_pkg::TB_ON_BIT])
			div_r <= '0;
		else if (tick_en)
			div_r <= div_nxt;
	end
	assign div_nxt = div_r + 1'b1;

	// overflow where the low bits of the chosen length wrap: top bit falls
	always_comb
	begin
		tick0_ovf = 1'b0;
		tick1_ovf = 1'b0;
		if (tick_en && tick_ctrl_r[irq_pkg::TB_ON_BIT])
		begin
			tick0_ovf = div_r[irq_pkg::TB0_BASE_EXP - 1 + int'(tick_ctrl_r[2:0])]
				&& !div_nxt[irq_pkg::TB0_BASE_EXP - 1 + int'(tick_ctrl_r[2:0])];
			tick1_ovf = div_r[irq_pkg::TB1_BASE_EXP - 1 + int'(tick_ctrl_r[5:4])]
				&& !div_nxt[irq_pkg::TB1_BASE_EXP - 1 + int'(tick_ctrl_r[5:4])];
		end
	end

	// slow crystal start mode bit goes out through one register stage
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			slow_crystal_low_power_o <= 1'b0;
		else
			slow_crystal_low_power_o <= tick_ctrl_r[irq_pkg::TB_LP_BIT];
	end

	// source and group enables
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			enable_r <= 8'h00;
		else if (wr_en)
			enable_r <= reg_wdata_i;
	end

	// timer match flags and enables, per compare pair
	for (genvar t = 0; t < NUM_TM; t++)
	begin : g_tm
		assign tm_set[2*t] = timer_match_a_i[t];
		assign tm_set[2*t+1] = timer_match_p_i[t];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			tm_en_r <= '0;
			tm_flag_r <= '0;
		end
		else
		begin
			if (wr_tmen)
				tm_en_r <= reg_wdata_i[2*NUM_TM-1:0];
			// set wins over software clear; never auto-cleared
			tm_flag_r <= (wr_tmf ? reg_wdata_i[2*NUM_TM-1:0] : tm_flag_r) | tm_set;
		end
	end

	// eeprom and low-supply flags, cleared only by software
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			group_r <= 4'h0;
		else
		begin
			group_r <= wr_grp ? reg_wdata_i[3:0] : group_r;
			if (eeprom_write_end_i)
				group_r[irq_pkg::GRP_EE_F] <= 1'b1;
			if (low_supply_detector_i)
				group_r[irq_pkg::GRP_LV_F] <= 1'b1;
		end
	end

	// group hits: a newly set enclosed flag, gated by its own enable
	assign grp_hit[0] = |(tm_set & tm_en_r);
	assign grp_hit[1] = eeprom_write_end_i && group_r[irq_pkg::GRP_EE_E];
	assign grp_hit[2] = low_supply_detector_i && group_r[irq_pkg::GRP_LV_E];

	// hardware set sources for the vectored flags
	always_comb
	begin
		src_set = 8'h00;
		src_set[irq_pkg::SRC_ADC] = conv_done_i;
		src_set[irq_pkg::SRC_TB0] = tick0_ovf;
		src_set[irq_pkg::SRC_TB1] = tick1_ovf;
		src_set[irq_pkg::SRC_SIM] = serial_event_i;
		src_set[irq_pkg::SRC_UART] = |uart_event_i;
		src_set[irq_pkg::SRC_MF0] = grp_hit[0];
		src_set[irq_pkg::SRC_MF1] = grp_hit[1];
		src_set[irq_pkg::SRC_MF2] = grp_hit[2];
	end

	// arbitration: lowest index first
	assign pending = flag_r & enable_r & {8{global_irq_enable_r && !stack_full_i}};
	assign grant = pending & (~pending + 8'd1);
	assign take_now = |grant && take_ready_i && !take_o;
	always_comb
	begin
		grant_idx = 3'd0;
		for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--)
			if (grant[i])
				grant_idx = 3'(i);
	end

	// request flags: hardware set wins, taking clears the granted one
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			flag_r <= 8'h00;
		else
			flag_r <= ((wr_flag ? reg_wdata_i : flag_r) & ~(take_now ? grant : 8'h00)) | src_set;
	end

	// global enable: cleared on take, set by return-from-interrupt or software
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			global_irq_enable_r <= 1'b0;
		else if (take_now)
			global_irq_enable_r <= 1'b0;
		else if (reti_i)
			global_irq_enable_r <= 1'b1;
		else if (reg_wr_i && reg_addr_i == irq_pkg::OFS_STATUS)
			global_irq_enable_r <= reg_wdata_i[0];
	end

	// push and vector to the core's sequencer
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			take_o <= 1'b0;
			push_pc_o <= 1'b0;
			vector_o <= 12'h000;
		end
		else
		begin
			take_o <= take_now;
			push_pc_o <= take_now;
			if (take_now)
				vector_o <= irq_pkg::VEC_BASE + irq_pkg::VEC_STEP * 12'(grant_idx);
		end
	end

	// wake on any request flag rising, source enables ignored
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			flag_prev_r <= 8'h00;
			wake_o <= 1'b0;
		end
		else
		begin
			flag_prev_r <= flag_r;
			wake_o <= |(flag_r & ~flag_prev_r);
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				irq_pkg::OFS_TICK_CTRL: reg_rdata_o <= tick_ctrl_r;
				irq_pkg::OFS_ENABLES: reg_rdata_o <= enable_r;
				irq_pkg::OFS_FLAGS: reg_rdata_o <= flag_r;
				irq_pkg::OFS_GROUP: reg_rdata_o <= {4'h0, group_r};
				irq_pkg::OFS_TIMER_EN: reg_rdata_o <= 8'(tm_en_r);
				irq_pkg::OFS_TIMER_FLAGS: reg_rdata_o <= 8'(tm_flag_r);
				irq_pkg::OFS_STATUS: reg_rdata_o <= {7'h00, global_irq_enable_r};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
		else
			reg_rdata_o <= 8'h00;
	end

	// checks
	sequence s_take;
		take_now;
	endsequence
	property p_gate;
		@(posedge ref_clk_i) disable iff (rst_i)
		take_now |-> global_irq_enable_r && !stack_full_i && |(flag_r & enable_r);
	endproperty
	a_gate: assert property (p_gate) else $error("take without enables");
	property p_gie_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_take |=> !global_irq_enable_r;
	endproperty
	a_gie_clear: assert property (p_gie_clear) else $error("global enable kept");
	property p_push;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_take |=> push_pc_o && take_o ##1 !take_o;
	endproperty
	a_push: assert property (p_push) else $error("push missing");
	property p_adc_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		take_now && grant_idx == 3'd0 && !conv_done_i |=> !flag_r[irq_pkg::SRC_ADC];
	endproperty
	a_adc_clear: assert property (p_adc_clear) else $error("adc flag stuck");
	property p_adc_set;
		@(posedge ref_clk_i) disable iff (rst_i)
		conv_done_i |=> flag_r[irq_pkg::SRC_ADC];
	endproperty
	a_adc_set: assert property (p_adc_set) else $error("adc flag not set");
	property p_tm_keep;
		@(posedge ref_clk_i) disable iff (rst_i)
		tm_flag_r[0] && !wr_tmf |=> tm_flag_r[0];
	endproperty
	a_tm_keep: assert property (p_tm_keep) else $error("timer flag lost");
	property p_wake;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(flag_r[irq_pkg::SRC_UART]) |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_reti;
		@(posedge ref_clk_i) disable iff (rst_i)
		reti_i && !take_now |=> global_irq_enable_r;
	endproperty
	a_reti: assert property (p_reti) else $error("reti ignored");
	property p_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		!tick_ctrl_r[irq_pkg::TB_ON_BIT] |-> !tick0_ovf && !tick1_ovf;
	endproperty
	a_off: assert property (p_off) else $error("tick while off");
endmodule
`default_nettype wire

// ==== dv/core_model.sv ====
// processor core model: return stack, take acceptance and return
`timescale 1ns/10ps
`default_nettype none
module core_model #(
	parameter int DEPTH = 1
)(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic take_i,
	input wire logic ret_i,
	input wire logic plain_i,
	input wire logic slow_i,
	output logic take_ready_o,
	output logic stack_full_o,
	output logic reti_o
);
	int depth_r;
	logic pop_r;
	// push on a take, pop on any return; slow mode accepts every other cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			depth_r <= 0;
			pop_r <= 1'b0;
			reti_o <= 1'b0;
			take_ready_o <= 1'b0;
		end
		else
		begin
			depth_r <= depth_r + int'(take_i) - int'(pop_r);
			pop_r <= ret_i;
			reti_o <= ret_i && !plain_i;
			take_ready_o <= slow_i ? !take_ready_o : 1'b1;
		end
	end
	// a full stack holds off further takes
	assign stack_full_o = (depth_r >= DEPTH);
endmodule
`default_nettype wire

// ==== dv/irq_timebase_tb.sv ====
// self-checking bench for the interrupt request and time-base block
`timescale 1ns/10ps
`default_nettype none
module irq_timebase_tb;
	logic ref_clk_i = 0, rst_i = 1, wr = 0, rd = 0, tick_clk = 0, ret = 0, slow = 0, plain = 0;
	logic [3:0] addr = 0, ev = 0;
	logic [7:0] wdata = 0, rdata;
	logic [5:0] uart = 0;
	logic [1:0] tma = 0, tmp = 0;
	logic take, push, wake, lp, ready, full, reti;
	logic [11:0] vec;
	logic [31:0] seed = 32'h8d23_8050;
	int errors = 0, n_checks = 0, n_take = 0, n_wake = 0, cyc = 0, t_last = 0, t_gap = 0;
	logic [11:0] exp_q[$];
	// system clock and a slow unrelated tick clock
	initial forever #5 ref_clk_i = ~ref_clk_i;
	always #80 tick_clk = ~tick_clk;
	irq_timebase dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.dedicated_tick_clock_i(tick_clk), .conv_done_i(ev[0]), .serial_event_i(ev[1]),
		.uart_event_i(uart), .eeprom_write_end_i(ev[2]), .low_supply_detector_i(ev[3]),
		.timer_match_a_i(tma), .timer_match_p_i(tmp), .stack_full_i(full),
		.take_ready_i(ready), .reti_i(reti), .take_o(take), .push_pc_o(push),
		.vector_o(vec), .wake_o(wake), .slow_crystal_low_power_o(lp));
	core_model core_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .take_i(take), .ret_i(ret),
		.plain_i(plain), .slow_i(slow), .take_ready_o(ready), .stack_full_o(full), .reti_o(reti));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
		n_checks++;
		if (seen !== expv)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// every take is compared with the reference vector queue
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (take === 1'b1)
		begin
			n_take++;
			t_gap = cyc - t_last;
			t_last = cyc;
			chk(push, 1);
			chk(vec, exp_q.size() ? exp_q.pop_front() : 12'hfff);
		end
		if (wake === 1'b1)
			n_wake++;
	end
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge ref_clk_i);
		wr <= 0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1;
		@(posedge ref_clk_i);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	// one-cycle event pulse; t holds {p1, a1, p0, a0} timer matches
	task automatic pulse(input logic [3:0] e, input logic [5:0] u, input logic [3:0] t);
		@(posedge ref_clk_i);
		ev <= e;
		uart <= u;
		tma <= {t[2], t[0]};
		tmp <= {t[3], t[1]};
		@(posedge ref_clk_i);
		ev <= 0;
		uart <= 0;
		tma <= 0;
		tmp <= 0;
	endtask
	// p selects a plain return instead of return-from-interrupt
	task automatic ret_any(input logic p);
		@(posedge ref_clk_i);
		ret <= 1;
		plain <= p;
		@(posedge ref_clk_i);
		ret <= 0;
		plain <= 0;
		repeat (2) @(posedge ref_clk_i);
	endtask
	task automatic ret_irq();
		ret_any(1'b0);
	endtask
	task automatic wait_take(input int target, input int bound);
		for (int i = 0; i < bound && n_take < target; i++)
			@(posedge ref_clk_i);
		#1 chk(16'(n_take), 16'(target));
		if (n_take < target)
			finish_test();
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 0;
		rd_reg(irq_pkg::OFS_TICK_CTRL, 8'h37);
		rd_reg(4'hf, 8'h00);
		wr_reg(irq_pkg::OFS_TICK_CTRL, 8'h08);
		rd_reg(irq_pkg::OFS_TICK_CTRL, 8'h08);
		chk(lp, 1);
		pulse(4'h1, 0, 0);
		repeat (4) @(posedge ref_clk_i);
		#1 chk(16'(n_wake), 1);
		rd_reg(irq_pkg::OFS_FLAGS, 8'h01);
		pulse(4'h1, 0, 0);
		repeat (4) @(posedge ref_clk_i);
		#1 chk(16'(n_wake), 1);
		wr_reg(irq_pkg::OFS_ENABLES, 8'h01);
		exp_q.push_back(12'h004);
		wr_reg(irq_pkg::OFS_STATUS, 8'h01);
		wait_take(1, 10);
		rd_reg(irq_pkg::OFS_FLAGS, 8'h00);
		rd_reg(irq_pkg::OFS_STATUS, 8'h00);
		// stack full holds off a pending enabled request
		pulse(4'h1, 0, 0);
		wr_reg(irq_pkg::OFS_STATUS, 8'h01);
		repeat (8) @(posedge ref_clk_i);
		chk(16'(n_take), 1);
		exp_q.push_back(12'h004);
		ret_irq();
		wait_take(2, 10);
		ret_irq();
		rd_reg(irq_pkg::OFS_STATUS, 8'h01);
		// simultaneous serial and uart requests, core speed from the random word
		seed = lfsr(seed);
		slow <= seed[7];
		wr_reg(irq_pkg::OFS_ENABLES, 8'h18);
		exp_q.push_back(12'h010);
		exp_q.push_back(12'h014);
		pulse(4'h2, 6'h01 << (seed % 6), 0);
		wait_take(3, 10);
		rd_reg(irq_pkg::OFS_FLAGS, 8'h10);
		ret_irq();
		wait_take(4, 10);
		rd_reg(irq_pkg::OFS_FLAGS, 8'h00);
		ret_irq();
		wr_reg(irq_pkg::OFS_ENABLES, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			pulse(0, 6'h01 << k, 0);
			rd_reg(irq_pkg::OFS_FLAGS, 8'h10);
			wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
		end
		// eeprom then low-supply through their groups
		for (int g = 0; g < 2; g++)
		begin
			wr_reg(irq_pkg::OFS_GROUP, 8'h04 << g);
			wr_reg(irq_pkg::OFS_ENABLES, 8'h40 << g);
			exp_q.push_back(12'h01c + 12'(4 * g));
			pulse(4'h4 << g, 0, 0);
			wait_take(5 + g, 10);
			rd_reg(irq_pkg::OFS_GROUP, 8'h05 << g);
			wr_reg(irq_pkg::OFS_GROUP, 8'h00);
			ret_irq();
		end
		wr_reg(irq_pkg::OFS_TIMER_EN, 8'h08);
		wr_reg(irq_pkg::OFS_ENABLES, 8'h20);
		exp_q.push_back(12'h018);
		pulse(0, 0, 4'h0c);
		wait_take(7, 10);
		rd_reg(irq_pkg::OFS_TIMER_FLAGS, 8'h0c);
		rd_reg(irq_pkg::OFS_STATUS, 8'h00);
		wr_reg(irq_pkg::OFS_TIMER_FLAGS, 8'h00);
		ret_any(1'b1);
		rd_reg(irq_pkg::OFS_STATUS, 8'h00);
		wr_reg(irq_pkg::OFS_STATUS, 8'h01);
		// dividers off, then dedicated clock tick0, then system clock tick1
		wr_reg(irq_pkg::OFS_ENABLES, 8'h00);
		wr_reg(irq_pkg::OFS_TICK_CTRL, 8'h40);
		wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
		repeat (1100) @(posedge ref_clk_i);
		rd_reg(irq_pkg::OFS_FLAGS, 8'h00);
		wr_reg(irq_pkg::OFS_ENABLES, 8'h02);
		exp_q.push_back(12'h008);
		wr_reg(irq_pkg::OFS_TICK_CTRL, 8'h80);
		wait_take(8, 4400);
		ret_irq();
		wr_reg(irq_pkg::OFS_ENABLES, 8'h04);
		exp_q.push_back(12'h00c);
		wr_reg(irq_pkg::OFS_TICK_CTRL, 8'hc0);
		wait_take(9, 16600);
		ret_irq();
		// tick0 code 1 on system clock over four: gap between two takes
		wr_reg(irq_pkg::OFS_TICK_CTRL, 8'hc1);
		wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
		wr_reg(irq_pkg::OFS_ENABLES, 8'h02);
		exp_q.push_back(12'h008);
		exp_q.push_back(12'h008);
		wait_take(10, 2200);
		ret_irq();
		wait_take(11, 2200);
		chk(16'(t_gap), 16'((1 << 9) * irq_pkg::SYS_DIV));
		chk(16'(exp_q.size()), 0);
		finish_test();
	end
endmodule
`default_nettype wire
